// File: hw/sdram_refresh_defs.svh
`ifndef SDRAM_REFRESH_DEFS_SVH
`define SDRAM_REFRESH_DEFS_SVH
// ------------------------------------------------------------
// command encodings {cs_n, ras_n, cas_n, we_n}
// ------------------------------------------------------------
`define CMD_NOP        4'h7
`define CMD_ACTIVE     4'h3
`define CMD_READ       4'h5
`define CMD_WRITE      4'h4
`define CMD_BURST_STOP 4'h6
`define CMD_PRECHARGE  4'h2
`define CMD_REFRESH    4'h1
`define CMD_LOAD_MODE  4'h0
// ------------------------------------------------------------
// sizes and timing
// ------------------------------------------------------------
`define ROW_W          13
`define ROWS           13'h1FFF
`define CLK_PERIOD_NS  40
`define BURST_W        10
`define FULL_PAGE_LEN  10'h3FF
// auto refreshes that cover every row once, and the period they must fit in
`define REFRESH_COUNT      14'h2000
`define REFRESH_PERIOD_NS  32'h03D09000
// internal self refresh clock: one refresh tick every this many cycles plus one
`define SELF_TICK_DIV  8'h1F
`endif

// File: hw/sdram_refresh_pkg.sv
package sdram_refresh_pkg;
    typedef enum logic [1:0] {ST_NORMAL, ST_SELF, ST_EXIT} refresh_state_t;
endpackage : sdram_refresh_pkg

// File: hw/sdram_refresh_and_burst_stop.sv
`timescale 1ns/1ns
// Summary of operation
// - burst stop ends the running burst, fixed length or full page.
// - the stopped burst is the latest read or write before the stop.
// - auto refresh uses internal row counter; address inputs ignored.
// - self refresh entry is the refresh command with clock enable low.
// - in self refresh only clock enable is looked at; it stays low.
// - in self refresh an internal tick drives the device's own refreshes.
// - refresh is cs ras cas low, we high; stop is cs we low.
`include "sdram_refresh_defs.svh"
module sdram_refresh_and_burst_stop
(
    input  wire logic                   clock_in,
    input  wire logic                   nrst_in,
    input  wire logic                   clock_enable_in,
    input  wire logic                   chip_select_n_in,
    input  wire logic                   row_strobe_n_in,
    input  wire logic                   column_strobe_n_in,
    input  wire logic                   write_enable_n_in,
    input  wire logic [`ROW_W-1:0]      address_in,
    input  wire logic                   full_page_in,
    input  wire logic [`BURST_W-1:0]    burst_length_in,
    output logic                        burst_active_out,
    output logic                        burst_is_write_out,
    output logic                        burst_stopped_out,
    output logic                        refresh_pulse_out,
    output logic [`ROW_W-1:0]           refresh_row_out,
    output logic                        self_refresh_out,
    output logic                        exit_busy_out
);
    import sdram_refresh_pkg::*;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    refresh_state_t   state_q;
    refresh_state_t   state_d;
    wire logic [3:0]  cmd;
    wire logic        is_read;
    wire logic        is_write;
    wire logic        is_stop;
    wire logic        is_refresh;
    wire logic        normal;
    wire logic        auto_refresh;
    wire logic        self_entry;

    assign cmd        = {chip_select_n_in, row_strobe_n_in, column_strobe_n_in,
                         write_enable_n_in};
    assign normal     = (state_q == ST_NORMAL);
    assign is_read    = normal && clock_enable_in && (cmd == `CMD_READ);
    assign is_write   = normal && clock_enable_in && (cmd == `CMD_WRITE);
    assign is_stop    = normal && clock_enable_in && (cmd == `CMD_BURST_STOP);
    assign is_refresh = normal && (cmd == `CMD_REFRESH);
    assign auto_refresh = is_refresh && clock_enable_in;
    assign self_entry   = is_refresh && !clock_enable_in;

    // ------------------------------------------------------------
    // burst tracking
    // ------------------------------------------------------------
    logic [`BURST_W-1:0] remain_q;
    logic [`BURST_W-1:0] remain_d;
    logic                active_d;
    logic                write_d;
    logic                stopped_d;
    wire logic [`BURST_W-1:0] start_len;

    // full page never ends on its own, so its count is held at one below the top count
    assign start_len = full_page_in ? `FULL_PAGE_LEN : burst_length_in;

    always_comb
    begin
        remain_d  = remain_q;
        active_d  = burst_active_out;
        write_d   = burst_is_write_out;
        stopped_d = 1'b0;
        if (is_read || is_write)
        begin
            // a new access replaces the old one, so a later stop hits it
            remain_d = start_len - 10'h001;
            active_d = (start_len != 10'h000);
            write_d  = is_write;
        end
        else if (is_stop)
        begin
            stopped_d = burst_active_out;
            active_d  = 1'b0;
            remain_d  = 10'h000;
        end
        else if (burst_active_out && !full_page_in)
        begin
            if (remain_q == 10'h000)
            begin
                active_d = 1'b0;
            end
            else
            begin
                remain_d = remain_q - 10'h001;
            end
        end
        if (self_entry)
        begin
            active_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // refresh sequencing
    // ------------------------------------------------------------
    logic [7:0] tick_q;
    logic [7:0] tick_d;
    logic [1:0] exit_cnt_q;
    logic [1:0] exit_cnt_d;
    wire logic  self_tick;
    wire logic  do_refresh;

    assign self_tick  = (state_q == ST_SELF) && (tick_q == `SELF_TICK_DIV);
    assign do_refresh = auto_refresh || self_entry || self_tick;

    always_comb
    begin
        state_d    = state_q;
        tick_d     = 8'h00;
        exit_cnt_d = 2'h0;
        case (state_q)
            ST_NORMAL:
            begin
                if (self_entry)
                begin
                    state_d = ST_SELF;
                end
            end
            ST_SELF:
            begin
                // every input but clock enable is ignored here
                tick_d = self_tick ? 8'h00 : tick_q + 8'h01;
                if (clock_enable_in)
                begin
                    state_d = ST_EXIT;
                end
            end
            ST_EXIT:
            begin
                // two clocks guard any internal refresh still finishing
                exit_cnt_d = exit_cnt_q + 2'h1;
                if (exit_cnt_q == 2'h1)
                begin
                    state_d = ST_NORMAL;
                end
            end
            default:
            begin
                state_d = ST_NORMAL;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q          <= ST_NORMAL;
            tick_q           <= 8'h00;
            exit_cnt_q       <= 2'h0;
            self_refresh_out <= 1'b0;
            exit_busy_out    <= 1'b0;
        end
        else
        begin
            state_q          <= state_d;
            tick_q           <= tick_d;
            exit_cnt_q       <= exit_cnt_d;
            // taken from the next state so the flags line up with state_q
            self_refresh_out <= (state_d == ST_SELF);
            exit_busy_out    <= (state_d == ST_EXIT);
        end
    end

    // ------------------------------------------------------------
    // burst registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            remain_q           <= 10'h000;
            burst_active_out   <= 1'b0;
            burst_is_write_out <= 1'b0;
            burst_stopped_out  <= 1'b0;
        end
        else
        begin
            remain_q           <= remain_d;
            burst_active_out   <= active_d;
            burst_is_write_out <= write_d;
            burst_stopped_out  <= stopped_d;
        end
    end

    // ------------------------------------------------------------
    // refresh row counter
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            refresh_pulse_out <= 1'b0;
            refresh_row_out   <= 13'h0000;
        end
        else
        begin
            refresh_pulse_out <= do_refresh;
            if (do_refresh)
            begin
                // address pins are never read for a refresh
                refresh_row_out <= (refresh_row_out == `ROWS) ? 13'h0000
                                   : refresh_row_out + 13'h0001;
            end
        end
    end
endmodule : sdram_refresh_and_burst_stop

// File: testbench/sdram_refresh_monitor.sv
`timescale 1ns/1ns
`include "sdram_refresh_defs.svh"
module sdram_refresh_monitor
(
    input  wire logic                   clock_in,
    input  wire logic                   nrst_in,
    input  wire logic                   clock_enable_in,
    input  wire logic                   full_page_in,
    input  wire logic                   chip_select_n_in,
    input  wire logic                   row_strobe_n_in,
    input  wire logic                   column_strobe_n_in,
    input  wire logic                   write_enable_n_in,
    input  wire logic [`BURST_W-1:0]    burst_length_in,
    input  wire logic                   burst_active_out,
    input  wire logic                   burst_is_write_out,
    input  wire logic                   burst_stopped_out,
    input  wire logic                   refresh_pulse_out,
    input  wire logic                   self_refresh_out,
    input  wire logic                   exit_busy_out,
    input  wire logic [`ROW_W-1:0]      refresh_row_out
);
    wire logic [3:0] cmd = {chip_select_n_in, row_strobe_n_in, column_strobe_n_in,
        write_enable_n_in};
    wire logic idle_w = !self_refresh_out && !exit_busy_out;
    wire logic rw_w = cmd == `CMD_READ || cmd == `CMD_WRITE;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence s_guard; exit_busy_out[*2] ##1 !exit_busy_out; endsequence
    property p_stop; idle_w && clock_enable_in && cmd == `CMD_BURST_STOP && burst_active_out
        |=> burst_stopped_out && !burst_active_out; endproperty
    property p_nostop; cmd == `CMD_BURST_STOP && !burst_active_out |=> !burst_stopped_out;
    endproperty
    property p_rw; idle_w && clock_enable_in && rw_w && (full_page_in || burst_length_in != 0)
        |=> burst_active_out && burst_is_write_out != $past(write_enable_n_in); endproperty
    property p_auto; idle_w && clock_enable_in && cmd == `CMD_REFRESH
        |=> refresh_pulse_out && refresh_row_out == $past(refresh_row_out) + 13'h1; endproperty
    property p_entry; idle_w && !clock_enable_in && cmd == `CMD_REFRESH
        |=> self_refresh_out && refresh_pulse_out; endproperty
    property p_hold; self_refresh_out && !clock_enable_in
        |=> self_refresh_out && !burst_active_out && !burst_stopped_out; endproperty
    property p_tick; self_refresh_out && refresh_pulse_out
        |-> ##[2:40] (refresh_pulse_out || !self_refresh_out); endproperty
    property p_exit; self_refresh_out && clock_enable_in |=> !self_refresh_out ##0 s_guard;
    endproperty
    a_stop: assert property (p_stop) else $error("stop missed");
    a_nostop: assert property (p_nostop) else $error("stray stop pulse");
    a_rw: assert property (p_rw) else $error("burst start wrong");
    a_auto: assert property (p_auto) else $error("auto refresh wrong");
    a_entry: assert property (p_entry) else $error("self entry wrong");
    a_hold: assert property (p_hold) else $error("self refresh left");
    a_tick: assert property (p_tick) else $error("no internal tick");
    a_exit: assert property (p_exit) else $error("exit guard wrong");
endmodule : sdram_refresh_monitor
bind sdram_refresh_and_burst_stop sdram_refresh_monitor i_mon (.*);

// File: testbench/sdram_ctrl_model.sv
`timescale 1ns/1ns
`include "sdram_refresh_defs.svh"
// never opens a row, so banks are idle before refresh
module sdram_ctrl_model
(
    input  wire logic              clock_in,
    output logic                   cke_out,
    output logic [3:0]             cmd_out,
    output logic [`ROW_W-1:0]      addr_out
);
    initial cke_out = 1'b1;
    initial cmd_out = `CMD_NOP;
    initial addr_out = 13'h0;
    // address is a don't care; it is negated each clock, so it stays at 13'h0
    always @(negedge clock_in) addr_out <= ~addr_out + 13'h1;
    // one command per clock, back to back allowed
    task automatic issue(input logic [3:0] c, input logic k);
        @(negedge clock_in);
        cmd_out = c;
        cke_out = k;
    endtask : issue
    task automatic nop(input int n);
        repeat (n)
        begin
            @(negedge clock_in);
            cmd_out = `CMD_NOP;
        end
    endtask : nop
endmodule : sdram_ctrl_model

// File: testbench/sdram_refresh_and_burst_stop_tb_top.sv
`timescale 1ns/1ns
`include "sdram_refresh_defs.svh"
module sdram_refresh_and_burst_stop_tb_top;
    logic clock_in;
    logic nrst_in;
    logic full_page;
    logic [`BURST_W-1:0] blen;
    longint t0;
    logic cke, act, wr, stp, pls, slf, exb;
    logic [3:0] cmd;
    logic [`ROW_W-1:0] addr, row, r;
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    sdram_ctrl_model i_ctrl (.clock_in(clock_in), .cke_out(cke), .cmd_out(cmd), .addr_out(addr));
    sdram_refresh_and_burst_stop i_dut (.clock_in(clock_in), .nrst_in(nrst_in),
        .clock_enable_in(cke), .chip_select_n_in(cmd[3]), .row_strobe_n_in(cmd[2]),
        .column_strobe_n_in(cmd[1]), .write_enable_n_in(cmd[0]), .address_in(addr),
        .full_page_in(full_page), .burst_length_in(blen), .burst_active_out(act),
        .burst_is_write_out(wr), .burst_stopped_out(stp), .refresh_pulse_out(pls),
        .refresh_row_out(row), .self_refresh_out(slf), .exit_busy_out(exb));
    task automatic chk(input logic [`ROW_W-1:0] got, input logic [`ROW_W-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    task automatic t_fixed;
        blen = 10'h004;
        i_ctrl.issue(`CMD_READ, 1'b1);
        i_ctrl.nop(4);
        chk(act, 1'b1);
        i_ctrl.nop(1);
        chk(act, 1'b0);
        i_ctrl.issue(`CMD_BURST_STOP, 1'b1);
        i_ctrl.nop(1);
        chk(stp, 1'b0);
        blen = 10'h002;
        i_ctrl.issue(`CMD_WRITE, 1'b1);
        i_ctrl.nop(1);
        chk({act, wr}, 2'h3);
        i_ctrl.issue(`CMD_BURST_STOP, 1'b1);
        i_ctrl.nop(1);
        chk({stp, act}, 2'h2);
        blen = 10'h000;
        i_ctrl.issue(`CMD_READ, 1'b1);
        i_ctrl.nop(1);
        chk(act, 1'b0);
    endtask : t_fixed
    task automatic t_page;
        full_page = 1'b1;
        i_ctrl.issue(`CMD_WRITE, 1'b1);
        i_ctrl.issue(`CMD_READ, 1'b1);
        i_ctrl.nop(20);
        chk(act, 1'b1);
        i_ctrl.issue(`CMD_BURST_STOP, 1'b1);
        i_ctrl.nop(1);
        chk({stp, act, wr}, 3'h4);
        full_page = 1'b0;
    endtask : t_page
    task automatic t_auto;
        r = row;
        repeat (3) i_ctrl.issue(`CMD_REFRESH, 1'b1);
        i_ctrl.nop(1);
        chk(row, r + 13'h3);
    endtask : t_auto
    task automatic t_wrap;
        r = row;
        t0 = $time;
        repeat (`REFRESH_COUNT) i_ctrl.issue(`CMD_REFRESH, 1'b1);
        i_ctrl.nop(1);
        chk(row, r);
        chk(($time - t0) < `REFRESH_PERIOD_NS, 1'b1);
    endtask : t_wrap
    task automatic t_reset;
        i_ctrl.issue(`CMD_REFRESH, 1'b0);
        i_ctrl.nop(1);
        chk(slf, 1'b1);
        nrst_in = 1'b0;
        i_ctrl.nop(1);
        chk({slf, exb, act, pls}, 4'h0);
        chk(row, 13'h0000);
        i_ctrl.issue(`CMD_NOP, 1'b1);
        nrst_in = 1'b1;
        i_ctrl.nop(1);
        chk(slf, 1'b0);
        i_ctrl.issue(`CMD_REFRESH, 1'b1);
        i_ctrl.nop(1);
        chk(row, 13'h0001);
    endtask : t_reset
    task automatic t_self;
        i_ctrl.issue(`CMD_REFRESH, 1'b0);
        i_ctrl.nop(1);
        chk({slf, pls}, 2'h3);
        i_ctrl.issue(`CMD_READ, 1'b0);
        n = 0;
        repeat (70)
        begin
            i_ctrl.nop(1);
            n += pls;
        end
        chk(n >= 2 && n <= 3, 1'b1);
        chk({slf, act}, 2'h2);
        i_ctrl.issue(`CMD_NOP, 1'b1);
        i_ctrl.nop(1);
        chk({slf, exb}, 2'h1);
        i_ctrl.nop(2);
        chk(exb, 1'b0);
        r = row;
        i_ctrl.issue(`CMD_REFRESH, 1'b1);
        i_ctrl.nop(1);
        chk(row, r + 13'h1);
    endtask : t_self
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        // about 8,500 cycles of tests; allow roughly three times that
        #1000000;
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        nrst_in   = 1'b0;
        full_page = 1'b0;
        blen      = 10'h004;
        repeat (8) @(posedge clock_in);
        @(negedge clock_in);
        nrst_in = 1'b1;
        t_fixed();
        t_page();
        t_auto();
        t_wrap();
        t_self();
        t_reset();
        tally_and_finish();
    end
endmodule : sdram_refresh_and_burst_stop_tb_top
